// >>> logic/atcc_pkg.sv
// Shared constants and types of the converter trigger and compare control
package atcc_pkg;
    // ------------------------------------------------------------
    // Register indices (byte address = 4 * index)
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_CTRL_ONE = 8'hE1;
    localparam logic [7:0] IDX_CTRL_TWO = 8'hE2;
    localparam logic [7:0] IDX_DELAY_LOW = 8'hE3;
    localparam logic [7:0] IDX_CTRL_ZERO = 8'hE8;
    localparam logic [7:0] IDX_RESULT_LOW = 8'hF0;
    localparam logic [7:0] IDX_RESULT_HIGH = 8'hF1;
    localparam logic [7:0] IDX_CMP_LOW = 8'hF2;
    localparam logic [7:0] IDX_CMP_HIGH = 8'hF3;
    localparam logic [7:0] IDX_IRQ_ENABLE = 8'hF4;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int B0_DONE = 7;
    localparam int B0_START = 6;
    localparam int B1_PIN_SEL = 6;
    localparam int B1_POWER = 0;
    localparam int B1_HW_EN = 1;
    localparam int B2_CMPO = 4;
    // ------------------------------------------------------------
    // Reset values and counts
    // ------------------------------------------------------------
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [5:0] SAMPLE_BASE_LAST = 6'h05;
    localparam logic [5:0] CONV_LAST = 6'h0B;
    localparam logic [3:0] CHAN_BANDGAP = 4'h8;
    localparam logic [3:0] CHAN_RESERVED = 4'h2;
    // ------------------------------------------------------------
    // Sequencer states, Gray along idle, sample, convert
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_SAMPLE = 2'h1,
        ST_CONVERT = 2'h3
    } atcc_state_type;
endpackage

// >>> logic/atcc_conv_if.sv
// Link between the control registers and the conversion sequencer
`timescale 1ns/100ps
`default_nettype none
interface atcc_conv_if;
    logic start;
    logic abort;
    logic [2:0] aqt;
    logic [1:0] div;
    logic tick;
    logic busy;
    logic sampling;
    logic done;
    logic [11:0] result;
    modport ctrl (output start, abort, aqt, div, input tick, busy, sampling, done, result);
    modport eng (input start, abort, aqt, div, output tick, busy, sampling, done, result);
endinterface
`default_nettype wire

// >>> logic/atcc_seq.sv
// Converter clock divider and sample / convert sequencer
`timescale 1ns/100ps
`default_nettype none
module atcc_seq (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic [11:0] sar_data,
    atcc_conv_if.eng conv
);
    import atcc_pkg::*;

    typedef struct packed {
        atcc_state_type state;
        logic [2:0] div_cnt;
        logic tick;
        logic [5:0] cnt;
        logic sampling;
        logic done;
        logic [11:0] result;
    } atcc_seq_st_type;

    atcc_seq_st_type st_q, st_d;
    logic [2:0] div_mask;
    logic [5:0] samp_last;

    always_comb begin
        case (conv.div)
            2'h0: div_mask = 3'h0;
            2'h1: div_mask = 3'h1;
            2'h2: div_mask = 3'h3;
            default: div_mask = 3'h7;
        endcase
        samp_last = {1'b0, conv.aqt, 2'h0} + SAMPLE_BASE_LAST;
        st_d = st_q;
        st_d.done = 1'b0;
        st_d.tick = (st_q.div_cnt == div_mask);
        st_d.div_cnt = (st_q.div_cnt == div_mask) ? 3'h0 : st_q.div_cnt + 3'h1;
        case (st_q.state)
            ST_IDLE: begin
                if (conv.start) begin
                    st_d.state = ST_SAMPLE;
                    st_d.cnt = 6'h00;
                    st_d.sampling = 1'b1;
                end
            end
            ST_SAMPLE: begin
                if (st_q.tick) begin
                    if (st_q.cnt == samp_last) begin
                        st_d.state = ST_CONVERT;
                        st_d.cnt = 6'h00;
                        st_d.sampling = 1'b0;
                    end else begin
                        st_d.cnt = st_q.cnt + 6'h01;
                    end
                end
            end
            ST_CONVERT: begin
                if (st_q.tick) begin
                    if (st_q.cnt == CONV_LAST) begin
                        st_d.state = ST_IDLE;
                        st_d.result = sar_data;
                        st_d.done = 1'b1;
                    end else begin
                        st_d.cnt = st_q.cnt + 6'h01;
                    end
                end
            end
            default: st_d.state = ST_IDLE;
        endcase
        // Power-down drops any conversion in flight
        if (conv.abort) begin
            st_d.state = ST_IDLE;
            st_d.sampling = 1'b0;
            st_d.done = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign conv.tick = st_q.tick;
    assign conv.busy = (st_q.state != ST_IDLE);
    assign conv.sampling = st_q.sampling;
    assign conv.done = st_q.done;
    assign conv.result = st_q.result;

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    sample_length_a: assert property (
        st_q.state == ST_SAMPLE && st_q.tick && st_q.cnt == samp_last && !conv.abort
        |=> st_q.state == ST_CONVERT && !st_q.sampling)
        else $error("sampling phase length wrong");
endmodule
`default_nettype wire

// >>> logic/atcc_top.sv
// Converter trigger, compare and register control with Avalon-MM slave
//
// What this block does
// - Hardware trigger starts conversion, sets busy bit
// - Starts while converting are dropped silently
// - Programmable delay before triggered conversion starts
// - Compare each 12-bit result when enabled
// - Polarity 0: result >= value; 1: less
// - Compare hit with brake enable pulses brake
// - Compare mode: repeat until hit, then done
// - Done flag with enable raises interrupt
// - Done flag blocks starts until software clears
// - Start bit: write 1 starts, reads busy
// - Source field picks PWM 0/2/4 or pin
// - Channel field routes input, reserved codes none
// - Pin location bit picks port bit 4/3
// - Divider gives system clock over 1/2/4/8
// - Type field: falling, rising, centre, end
// - Hardware enable adds hardware starts to software
// - Power bit gates all conversions
// - Sampling lasts 4 times field plus 6
// - Delay counter is 9 bits, MSB elsewhere
// - Result split: upper 8, lower 4 bits
//
// Chosen here: the Avalon-MM register port.
`timescale 1ns/100ps
`default_nettype none
module atcc_top (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic [9:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic pwm_ch0,
    input wire logic pwm_ch2,
    input wire logic pwm_ch4,
    input wire logic pwm_period_centre,
    input wire logic pwm_period_end,
    input wire logic port0_bit3,
    input wire logic port0_bit4,
    input wire logic [11:0] sar_data,
    output logic converter_power_on,
    output logic [8:0] sampler_channel,
    output logic sampler_sampling,
    output logic fault_brake,
    output logic irq
);
    import atcc_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic wreq;
        logic [7:0] rdata;
        logic [5:0] c0;
        logic [7:0] c1;
        logic fb_en;
        logic pol;
        logic cmp_en;
        logic cmpo;
        logic [2:0] aqt;
        logic dly8;
        logic [7:0] dly_lo;
        logic [11:0] cmp_val;
        logic [11:0] res;
        logic irq_en;
        logic busy;
        logic done;
        logic start;
        logic pend;
        logic [8:0] dcnt;
        logic prev_lvl;
        logic [8:0] chan;
        logic brake;
        logic irq;
    } atcc_st_type;

    atcc_st_type st_q, st_d;
    atcc_conv_if conv ();

    logic [7:0] idx;
    logic addr_ok;
    logic wr_take;
    logic pin_lvl;
    logic src_lvl;
    logic hw_evt;
    logic can_start;
    logic hw_accept;
    logic sw_start;
    logic cmp_hit;

    atcc_seq u_seq (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .sar_data(sar_data),
        .conv(conv)
    );

    assign conv.start = st_q.start;
    assign conv.abort = ~st_q.c1[B1_POWER];
    assign conv.aqt = st_q.aqt;
    assign conv.div = st_q.c1[5:4];

    // ------------------------------------------------------------
    // Trigger selection
    // ------------------------------------------------------------
    always_comb begin
        pin_lvl = st_q.c1[B1_PIN_SEL] ? port0_bit3 : port0_bit4;
        case (st_q.c0[5:4])
            2'h0: src_lvl = pwm_ch0;
            2'h1: src_lvl = pwm_ch2;
            2'h2: src_lvl = pwm_ch4;
            default: src_lvl = pin_lvl;
        endcase
        case (st_q.c1[3:2])
            2'h0: hw_evt = st_q.prev_lvl && !src_lvl;
            2'h1: hw_evt = !st_q.prev_lvl && src_lvl;
            2'h2: hw_evt = pwm_period_centre;
            default: hw_evt = pwm_period_end;
        endcase
    end

    // Busy covers the trigger delay too, so a second trigger cannot
    // restart the delay count.
    assign can_start = st_q.c1[B1_POWER] && !st_q.busy && !st_q.done;
    assign hw_accept = st_q.c1[B1_HW_EN] && hw_evt && can_start;
    assign idx = avs_address[9:2];
    assign addr_ok = (avs_address[1:0] == 2'h0);
    assign wr_take = avs_write && !st_q.wreq && addr_ok && avs_byteenable[0];
    assign sw_start = wr_take && idx == IDX_CTRL_ZERO && avs_writedata[B0_START] && can_start;
    assign cmp_hit = st_q.pol ? (conv.result < st_q.cmp_val) : (conv.result >= st_q.cmp_val);

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        st_d.start = 1'b0;
        st_d.brake = 1'b0;
        st_d.prev_lvl = src_lvl;
        // One wait state: answer a cycle after the request appears
        st_d.wreq = !((avs_read || avs_write) && st_q.wreq);
        if (avs_read && st_q.wreq) begin
            st_d.rdata = RST_BYTE;
            if (addr_ok) begin
                case (idx)
                    IDX_CTRL_ZERO: st_d.rdata = {st_q.done, st_q.busy, st_q.c0};
                    IDX_CTRL_ONE: st_d.rdata = st_q.c1;
                    IDX_CTRL_TWO: st_d.rdata = {st_q.fb_en, st_q.pol, st_q.cmp_en, st_q.cmpo, st_q.aqt, st_q.dly8};
                    IDX_DELAY_LOW: st_d.rdata = st_q.dly_lo;
                    IDX_RESULT_HIGH: st_d.rdata = st_q.res[11:4];
                    IDX_RESULT_LOW: st_d.rdata = {4'h0, st_q.res[3:0]};
                    IDX_CMP_HIGH: st_d.rdata = st_q.cmp_val[11:4];
                    IDX_CMP_LOW: st_d.rdata = {4'h0, st_q.cmp_val[3:0]};
                    IDX_IRQ_ENABLE: st_d.rdata = {7'h00, st_q.irq_en};
                    default: st_d.rdata = RST_BYTE;
                endcase
            end
        end
        if (wr_take) begin
            case (idx)
                IDX_CTRL_ZERO: begin
                    st_d.c0 = avs_writedata[5:0];
                    if (!avs_writedata[B0_DONE]) begin
                        st_d.done = 1'b0;
                    end
                end
                IDX_CTRL_ONE: st_d.c1 = avs_writedata[7:0];
                IDX_CTRL_TWO: begin
                    st_d.fb_en = avs_writedata[7];
                    st_d.pol = avs_writedata[6];
                    st_d.cmp_en = avs_writedata[5];
                    st_d.aqt = avs_writedata[3:1];
                    st_d.dly8 = avs_writedata[0];
                end
                IDX_DELAY_LOW: st_d.dly_lo = avs_writedata[7:0];
                IDX_CMP_HIGH: st_d.cmp_val[11:4] = avs_writedata[7:0];
                IDX_CMP_LOW: st_d.cmp_val[3:0] = avs_writedata[3:0];
                IDX_IRQ_ENABLE: st_d.irq_en = avs_writedata[0];
                default: st_d.irq_en = st_q.irq_en;
            endcase
        end
        // Hardware trigger: mark busy now, start after the delay
        if (hw_accept) begin
            st_d.busy = 1'b1;
            st_d.pend = 1'b1;
            st_d.dcnt = {st_q.dly8, st_q.dly_lo};
        end
        if (sw_start) begin
            st_d.busy = 1'b1;
            st_d.pend = 1'b0;
            st_d.start = 1'b1;
        end
        if (st_q.pend && conv.tick) begin
            if (st_q.dcnt == 9'h000) begin
                st_d.pend = 1'b0;
                st_d.start = 1'b1;
            end else begin
                st_d.dcnt = st_q.dcnt - 9'h001;
            end
        end
        // Completion comes after the software clear so the set wins
        if (conv.done) begin
            st_d.res = conv.result;
            if (st_q.cmp_en) begin
                st_d.cmpo = cmp_hit;
                if (cmp_hit) begin
                    st_d.done = 1'b1;
                    st_d.busy = 1'b0;
                    st_d.brake = st_q.fb_en;
                end else begin
                    st_d.start = 1'b1;
                end
            end else begin
                st_d.done = 1'b1;
                st_d.busy = 1'b0;
            end
        end
        if (!st_q.c1[B1_POWER]) begin
            st_d.busy = 1'b0;
            st_d.pend = 1'b0;
            st_d.start = 1'b0;
        end
        // Channel routing; code 0110 lands on channel 6 naturally
        for (int i = 0; i < 9; i++) begin
            st_d.chan[i] = st_q.c1[B1_POWER] && st_q.c0[3:0] == 4'(i) && st_q.c0[3:0] != CHAN_RESERVED;
        end
        st_d.irq = st_q.done && st_q.irq_en;
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            st_q <= '0;
            st_q.wreq <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    assign avs_readdata = {24'h000000, st_q.rdata};
    assign avs_waitrequest = st_q.wreq;
    assign converter_power_on = st_q.c1[B1_POWER];
    assign sampler_channel = st_q.chan;
    assign sampler_sampling = conv.sampling;
    assign fault_brake = st_q.brake;
    assign irq = st_q.irq;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    sequence hw_taken_s;
        hw_accept && !sw_start;
    endsequence

    sequence delay_run_s;
        st_q.busy && st_q.pend;
    endsequence

    hw_sets_busy_a: assert property (hw_taken_s |=> delay_run_s)
        else $error("hardware trigger did not set busy");

    busy_discard_a: assert property (
        st_q.busy && !st_q.pend && !conv.done |=> !st_q.start)
        else $error("start issued while converting");

    delay_exact_a: assert property (
        hw_taken_s ##1 (st_q.dcnt == 9'h000 && conv.tick && st_q.c1[B1_POWER]) |=> st_q.start)
        else $error("delayed start not issued");

    compare_sense_a: assert property (
        conv.done && st_q.cmp_en |=> st_q.cmpo == (st_q.pol ? (st_q.res < st_q.cmp_val) : (st_q.res >= st_q.cmp_val)))
        else $error("compare output wrong");

    brake_pulse_a: assert property (
        conv.done && st_q.cmp_en && cmp_hit && st_q.fb_en |=> fault_brake ##1 !fault_brake)
        else $error("fault brake pulse wrong");

    compare_repeat_a: assert property (
        conv.done && st_q.cmp_en && !cmp_hit && st_q.c1[B1_POWER] |=> st_q.start && st_q.busy && !$rose(st_q.done))
        else $error("compare miss did not restart");

    irq_follow_a: assert property (
        st_q.done && st_q.irq_en [*2] |-> irq)
        else $error("interrupt missing");

    done_blocks_a: assert property (st_q.done && !st_q.busy |=> !st_q.start)
        else $error("start while done flag set");

    busy_clear_a: assert property (
        conv.done && !st_q.cmp_en |=> !st_q.busy && st_q.done)
        else $error("busy not cleared at completion");

    power_off_a: assert property (!st_q.c1[B1_POWER] |=> sampler_channel == 9'h000 && !st_q.busy)
        else $error("conversion or channel while powered off");

    bandgap_route_a: assert property (
        st_q.c1[B1_POWER] && st_q.c0[3:0] == CHAN_BANDGAP |=> sampler_channel == 9'h100)
        else $error("band-gap not routed");

    sw_start_busy_a: assert property (sw_start |=> st_q.busy && st_q.start)
        else $error("software start not taken");

    hw_off_quiet_a: assert property (!st_q.c1[B1_HW_EN] && !st_q.pend |=> !st_q.pend)
        else $error("hardware start while disabled");

    source_pick_a: assert property (st_q.c0[5:4] == 2'h2 |-> src_lvl == pwm_ch4)
        else $error("trigger source wrong");

    pin_pick_a: assert property (!st_q.c1[B1_PIN_SEL] |-> pin_lvl == port0_bit4)
        else $error("start pin location wrong");

    falling_take_a: assert property (
        st_q.c1[B1_HW_EN] && st_q.c1[3:2] == 2'h0 && can_start && st_q.prev_lvl && !src_lvl |=> st_q.busy)
        else $error("falling edge not taken");

    delay_load_a: assert property (
        hw_taken_s |=> st_q.dcnt == {$past(st_q.dly8), $past(st_q.dly_lo)})
        else $error("delay count not loaded");

    result_keep_a: assert property (conv.done |=> st_q.res == $past(conv.result))
        else $error("result not stored");

    cmpo_hold_a: assert property (!conv.done |=> $stable(st_q.cmpo))
        else $error("compare output moved without completion");

    chan_six_a: assert property (
        st_q.c1[B1_POWER] && st_q.c0[3:0] == 4'h6 |=> sampler_channel == 9'h040)
        else $error("channel 6 not routed");

    reserved_none_a: assert property (st_q.c0[3:0] == CHAN_RESERVED |=> sampler_channel == 9'h000)
        else $error("reserved channel routed");
endmodule
`default_nettype wire

// >>> test/atcc_pwm_model.sv
// Behavioural PWM unit, external start pin and converter data source
`timescale 1ns/100ps
`default_nettype none
module atcc_pwm_model (
    input wire logic clk_sys,
    input wire logic [2:0] ev_sel,
    input wire logic ev_go,
    input wire logic [11:0] conv_value,
    output logic pwm_ch0,
    output logic pwm_ch2,
    output logic pwm_ch4,
    output logic pwm_period_centre,
    output logic pwm_period_end,
    output logic port0_bit3,
    output logic port0_bit4,
    output logic [11:0] sar_data
);
    logic [4:0] lvl_q;
    logic centre_q;
    logic end_q;

    // ------------------------------------------------
    // Line levels and period pulses
    // ------------------------------------------------
    initial begin
        lvl_q = 5'h00;
        centre_q = 1'b0;
        end_q = 1'b0;
    end

    // Period points are single-cycle pulses, as in centre-aligned mode
    always @(posedge clk_sys) begin
        centre_q <= ev_go && ev_sel == 3'h5;
        end_q <= ev_go && ev_sel == 3'h6;
        if (ev_go && ev_sel < 3'h5) begin
            lvl_q[ev_sel] <= ~lvl_q[ev_sel];
        end
    end

    assign {port0_bit3, port0_bit4, pwm_ch4, pwm_ch2, pwm_ch0} = lvl_q;
    assign pwm_period_centre = centre_q;
    assign pwm_period_end = end_q;
    assign sar_data = conv_value;
endmodule
`default_nettype wire

// >>> test/tb.sv
// Self-checking bench of the converter trigger and compare control
`timescale 1ns/100ps
`default_nettype none
module tb;
    import atcc_pkg::*;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic [9:0] avs_address = 10'h000;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [2:0] ev_sel = 3'h0;
    logic ev_go = 1'b0;
    logic [11:0] conv_value = 12'h000;
    logic [11:0] sar_data;
    logic [8:0] sampler_channel;
    logic pwm_ch0, pwm_ch2, pwm_ch4, pwm_period_centre, pwm_period_end, port0_bit3, port0_bit4;
    logic converter_power_on, sampler_sampling, fault_brake, irq;
    logic [7:0] rd;
    logic [7:0] z_cfg;
    logic [4:0] lvl = 5'h00;
    logic [11:0] v;
    int bad_count = 0;
    int compares = 0;
    int brakes = 0;
    int samp_run = 0;
    int samp_len = 0;
    int samp_cnt = 0;
    int c0;
    int i;
    int j;

    always #25 clk_sys = ~clk_sys;

    // Length and number of sampling windows, and brake pulses
    always @(posedge clk_sys) begin
        if (fault_brake === 1'b1) brakes <= brakes + 1;
        if (sampler_sampling === 1'b1) begin
            samp_run <= samp_run + 1;
        end else if (samp_run != 0) begin
            samp_len <= samp_run;
            samp_cnt <= samp_cnt + 1;
            samp_run <= 0;
        end
    end

    atcc_top uut (
        .clk_sys, .rstn, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest, .pwm_ch0, .pwm_ch2, .pwm_ch4,
        .pwm_period_centre, .pwm_period_end, .port0_bit3, .port0_bit4, .sar_data,
        .converter_power_on, .sampler_channel, .sampler_sampling, .fault_brake, .irq
    );
    atcc_pwm_model pwm (
        .clk_sys, .ev_sel, .ev_go, .conv_value, .pwm_ch0, .pwm_ch2, .pwm_ch4, .pwm_period_centre,
        .pwm_period_end, .port0_bit3, .port0_bit4, .sar_data
    );

    // ------------------------------------------------
    // Bus and check tasks
    // ------------------------------------------------
    task automatic summarize();
        $display("bad_count %0d compares %0d", bad_count, compares);
        if (bad_count == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [11:0] got, input logic [11:0] e);
        compares++;
        if (got !== e) begin
            bad_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, e);
        end
    endtask
    task automatic fail_wait();
        bad_count++;
        $display("[ERR] %0t wait limit reached", $time);
        summarize();
    endtask
    task automatic cycles(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    // Registered outputs, so values read after the edge are those sampled at it
    task automatic bus(input logic wr_en, input logic [7:0] idx, input logic [7:0] d);
        int n = 0;
        @(posedge clk_sys);
        avs_address <= {idx, 2'b00};
        avs_writedata <= {24'h0, d};
        avs_write <= wr_en;
        avs_read <= ~wr_en;
        do begin
            @(posedge clk_sys);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        if (n >= 20) fail_wait();
        rd = avs_readdata[7:0];
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        bus(1'b1, idx, d);
    endtask
    task automatic rdc(input logic [7:0] idx, input logic [7:0] e);
        bus(1'b0, idx, 8'h00);
        chk(12'(rd), 12'(e));
    endtask
    task automatic wait_done();
        int n = 0;
        do begin
            bus(1'b0, IDX_CTRL_ZERO, 8'h00);
            n++;
        end while (rd[B0_DONE] !== 1'b1 && n < 200);
        if (n >= 200) fail_wait();
    endtask
    task automatic go(input int sel);
        ev_sel <= 3'(sel);
        ev_go <= 1'b1;
        @(posedge clk_sys);
        ev_go <= 1'b0;
    endtask
    task automatic fire(input int sel, input logic e);
        go(sel);
        cycles(40);
        bus(1'b0, IDX_CTRL_ZERO, 8'h00);
        chk(12'(rd[B0_DONE]), 12'(e));
        wr(IDX_CTRL_ZERO, z_cfg);
    endtask

    // ------------------------------------------------
    // Main sequence
    // ------------------------------------------------
    initial begin
        repeat (20) @(posedge clk_sys);
        rstn <= 1'b1;
        rdc(IDX_CTRL_ZERO, RST_BYTE);
        rdc(IDX_CTRL_ONE, RST_BYTE);
        rdc(IDX_CTRL_TWO, RST_BYTE);
        wr(IDX_CTRL_TWO, 8'h10);
        rdc(IDX_CTRL_TWO, 8'h00);
        wr(IDX_CTRL_ONE, 8'hFE);
        rdc(IDX_CTRL_ONE, 8'hFE);
        rdc(8'h10, 8'h00);
        wr(IDX_CTRL_ZERO, 8'h40);
        cycles(40);
        rdc(IDX_CTRL_ZERO, 8'h00);
        wr(IDX_CTRL_ONE, 8'h01);
        for (i = 0; i < 16; i++) begin
            wr(IDX_CTRL_ZERO, {4'h0, i[3:0]});
            cycles(2);
            chk(12'(sampler_channel), (i < 9 && i != CHAN_RESERVED) ? 12'(1 << i) : 12'h000);
        end
        wr(IDX_CTRL_ONE, 8'h00);
        cycles(2);
        chk(12'(sampler_channel), 12'h000);
        chk(12'(converter_power_on), 12'h000);
        wr(IDX_IRQ_ENABLE, 8'h01);
        for (i = 0; i < 4; i++) begin
            v = 12'h3C5 + 12'(i * 273);
            conv_value <= v;
            wr(IDX_CTRL_ONE, {2'b00, i[1:0], 4'h1});
            wr(IDX_CTRL_TWO, {4'h0, i[2:0], 1'b0});
            c0 = samp_cnt;
            wr(IDX_CTRL_ZERO, 8'h41);
            rdc(IDX_CTRL_ZERO, 8'h41);
            wr(IDX_CTRL_ZERO, 8'h41);
            wait_done();
            chk(12'(rd), 12'h081);
            chk(12'(samp_cnt - c0), 12'h001);
            chk(12'(samp_len > ((4 * i + 5) << i) && samp_len <= ((4 * i + 6) << i)), 12'h001);
            rdc(IDX_RESULT_HIGH, v[11:4]);
            rdc(IDX_RESULT_LOW, 8'(v[3:0]));
            chk(12'(irq), 12'h001);
            wr(IDX_CTRL_ZERO, 8'hC1);
            cycles(30);
            rdc(IDX_CTRL_ZERO, 8'h81);
            wr(IDX_CTRL_ZERO, 8'h01);
            cycles(30);
            chk(12'(samp_cnt - c0), 12'h001);
            chk(12'(irq), 12'h000);
        end
        wr(IDX_CTRL_TWO, 8'h00);
        // Band-gap: the first three results after power-up are thrown away
        conv_value <= 12'h64E;
        wr(IDX_CTRL_ONE, 8'h00);
        wr(IDX_CTRL_ONE, 8'h01);
        repeat (4) begin
            wr(IDX_CTRL_ZERO, 8'h48);
            wait_done();
            wr(IDX_CTRL_ZERO, 8'h08);
        end
        chk(12'(sampler_channel), 12'h100);
        chk(12'(converter_power_on), 12'h001);
        rdc(IDX_RESULT_HIGH, 8'h64);
        rdc(IDX_RESULT_LOW, 8'h0E);
        // Every line is back low before the source field moves
        for (i = 0; i < 4; i++) begin
            for (j = 0; j < 2; j++) begin
                z_cfg = {2'b00, i[1:0], 4'h1};
                wr(IDX_CTRL_ZERO, z_cfg);
                wr(IDX_CTRL_ONE, {4'h0, j[1:0], 2'b11});
                repeat (2) begin
                    lvl[i] = ~lvl[i];
                    fire(i, lvl[i] == j[0]);
                end
            end
        end
        z_cfg = 8'h31;
        wr(IDX_CTRL_ZERO, z_cfg);
        wr(IDX_CTRL_ONE, 8'h47);
        for (i = 3; i < 5; i++) begin
            repeat (2) begin
                lvl[i] = ~lvl[i];
                fire(i, i == 4 && lvl[i]);
            end
        end
        wr(IDX_CTRL_ONE, 8'h05);
        repeat (2) begin
            lvl[3] = ~lvl[3];
            fire(3, 1'b0);
        end
        for (j = 2; j < 4; j++) begin
            wr(IDX_CTRL_ONE, {4'h0, j[1:0], 2'b11});
            fire(5, j == 2);
            fire(6, j == 3);
        end
        wr(IDX_CTRL_ONE, 8'h07);
        wr(IDX_DELAY_LOW, 8'h00);
        wr(IDX_CTRL_TWO, 8'h01);
        go(3);
        cycles(200);
        rdc(IDX_CTRL_ZERO, 8'h71);
        cycles(150);
        rdc(IDX_CTRL_ZERO, 8'hB1);
        wr(IDX_CTRL_ONE, 8'h01);
        wr(IDX_CMP_HIGH, 8'h80);
        wr(IDX_CMP_LOW, 8'h04);
        // Done from the delayed start would refuse the first start below
        wr(IDX_CTRL_ZERO, 8'h01);
        for (i = 0; i < 2; i++) begin
            conv_value <= i ? 12'h804 : 12'h803;
            wr(IDX_CTRL_TWO, {1'b1, i[0], 6'h20});
            j = brakes;
            c0 = samp_cnt;
            wr(IDX_CTRL_ZERO, 8'h41);
            cycles(150);
            rdc(IDX_CTRL_ZERO, 8'h41);
            chk(12'(samp_cnt - c0 > 3), 12'h001);
            chk(12'(brakes - j), 12'h000);
            conv_value <= i ? 12'h803 : 12'h804;
            wait_done();
            rdc(IDX_CTRL_TWO, 8'hB0 | 8'(i << 6));
            rdc(IDX_RESULT_LOW, 8'h04 - 8'(i));
            chk(12'(brakes - j), 12'h001);
            wr(IDX_CTRL_ZERO, 8'h01);
        end
        summarize();
    end
endmodule
`default_nettype wire
